// ### logic/periph_irq_pkg.sv
// Package with register map, field positions and bus types of the block.
package periph_irq_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 8;

  // Byte addresses of the registers on the bus.
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_ONE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_TWO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PWM_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_REQUEST_ONE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REQUEST_TWO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PWM_REQUEST = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h20;

  // Implemented-bit masks; every other position reads zero.
  localparam logic [REG_W-1:0] MASK_CORE_CTRL = 8'hC0;
  localparam logic [REG_W-1:0] MASK_ONE = 8'hF3;
  localparam logic [REG_W-1:0] MASK_TWO = 8'h20;
  localparam logic [REG_W-1:0] MASK_PWM = 8'h70;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // Field positions.
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;
  localparam int unsigned BIT_T1_GATE = 7;
  localparam int unsigned BIT_CONV_DONE = 6;
  localparam int unsigned BIT_SER_RX = 5;
  localparam int unsigned BIT_SER_TX = 4;
  localparam int unsigned BIT_T2_MATCH = 1;
  localparam int unsigned BIT_T1_OVF = 0;
  localparam int unsigned BIT_COMPARATOR = 5;
  localparam int unsigned BIT_CHAN3 = 6;
  localparam int unsigned BIT_CHAN2 = 5;
  localparam int unsigned BIT_CHAN1 = 4;

  // Event status bits: 0 request raised, 1 request dropped, 2 bus error.
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_RISE = 0;
  localparam int unsigned EVT_FALL = 1;
  localparam int unsigned EVT_ERR = 2;

  // Condition pulses from the peripherals, one cycle each.
  typedef struct packed {
    logic timer_one_gate;
    logic converter_done;
    logic serial_rx;
    logic serial_tx;
    logic timer_two_match;
    logic timer_one_overflow;
    logic comparator;
  } periph_cond_t;

  // Pending levels of the three wave channels, kept inside each channel.
  typedef struct packed {
    logic chan3;
    logic chan2;
    logic chan1;
  } wave_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

endpackage : periph_irq_pkg

// ### logic/periph_irq_flags.sv
// Peripheral interrupt enable and request registers with APB access.
//
// Function
// - The wave enable register holds channel 3, 2 and 1 enables at 6, 5, 4.
// - Unimplemented bits of all these registers read zero and ignore writes.
// - Request register one holds read/write pending flags at 7,6,5,4,1,0.
// - Request register two holds one read/write comparator flag at bit 5.
// - A flag sets on its condition regardless of any enable.
// - Wave request bits mirror the channels' flags and ignore writes.
// - No source reaches core_irq_o unless the peripheral enable is set; periph_req_o ignores it.
// - Every implemented bit resets to zero on any reset.
// - Control bit 7 is the global enable that gates the core interrupt request.
// - Control bit 6 is the peripheral enable for all peripheral sources.
// - Enable register one mirrors request register one bit for bit.
// - Enable register two holds the comparator enable at bit 5.
`timescale 1ns/1ps

module periph_irq_flags
  import periph_irq_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // APB slave.
  input wire periph_irq_pkg::apb_req_t apb_i,
  output periph_irq_pkg::apb_rsp_t apb_o,
  // Peripheral conditions and channel flag levels.
  input wire periph_irq_pkg::periph_cond_t cond_i,
  input wire periph_irq_pkg::wave_flags_t wave_flags_i,
  // Requests towards the core.
  output logic periph_req_o,
  output logic core_irq_o,
  output logic evt_irq_o
);
  import periph_irq_pkg::*;

  logic [REG_W-1:0] core_irq_control, next_core_irq_control;
  logic [REG_W-1:0] periph_irq_enable_one, next_periph_irq_enable_one;
  logic [REG_W-1:0] periph_irq_enable_two, next_periph_irq_enable_two;
  logic [REG_W-1:0] pwm_irq_enable, next_pwm_irq_enable;
  logic [REG_W-1:0] periph_irq_request_one, next_periph_irq_request_one;
  logic [REG_W-1:0] periph_irq_request_two, next_periph_irq_request_two;
  logic [REG_W-1:0] pwm_irq_request, next_pwm_irq_request;
  logic [EVT_W-1:0] evt_status, next_evt_status;
  logic [EVT_W-1:0] evt_mask, next_evt_mask;
  apb_rsp_t rsp, next_rsp;
  logic periph_req, next_periph_req;
  logic core_irq, next_core_irq;
  logic evt_irq, next_evt_irq;

  logic access, wr, rd, hit;
  logic [REG_W-1:0] wdat;
  logic [REG_W-1:0] set_one, set_two, set_pwm;
  logic [REG_W-1:0] rdat;
  logic any_pending;

  // Single-cycle access phase: pready rises with the first penable cycle.
  assign access = apb_i.psel && apb_i.penable;
  assign wr = access && apb_i.pwrite;
  assign rd = access && !apb_i.pwrite;
  assign wdat = apb_i.pwdata[REG_W-1:0];

  always_comb begin
    set_one = REG_RESET;
    set_one[BIT_T1_GATE] = cond_i.timer_one_gate;
    set_one[BIT_CONV_DONE] = cond_i.converter_done;
    set_one[BIT_SER_RX] = cond_i.serial_rx;
    set_one[BIT_SER_TX] = cond_i.serial_tx;
    set_one[BIT_T2_MATCH] = cond_i.timer_two_match;
    set_one[BIT_T1_OVF] = cond_i.timer_one_overflow;
    set_two = REG_RESET;
    set_two[BIT_COMPARATOR] = cond_i.comparator;
    set_pwm = REG_RESET;
    set_pwm[BIT_CHAN3] = wave_flags_i.chan3;
    set_pwm[BIT_CHAN2] = wave_flags_i.chan2;
    set_pwm[BIT_CHAN1] = wave_flags_i.chan1;
  end

  always_comb begin
    hit = 1'b1;
    case (apb_i.paddr)
      OFS_CORE_CTRL: rdat = core_irq_control;
      OFS_ENABLE_ONE: rdat = periph_irq_enable_one;
      OFS_ENABLE_TWO: rdat = periph_irq_enable_two;
      OFS_PWM_ENABLE: rdat = pwm_irq_enable;
      OFS_REQUEST_ONE: rdat = periph_irq_request_one;
      OFS_REQUEST_TWO: rdat = periph_irq_request_two;
      OFS_PWM_REQUEST: rdat = pwm_irq_request;
      OFS_EVT_STATUS: rdat = {{(REG_W-EVT_W){1'b0}}, evt_status};
      OFS_EVT_MASK: rdat = {{(REG_W-EVT_W){1'b0}}, evt_mask};
      default: begin
        rdat = REG_RESET;
        hit = 1'b0;
      end
    endcase
  end

  // Register writes and flag updates.
  always_comb begin
    next_core_irq_control = core_irq_control;
    next_periph_irq_enable_one = periph_irq_enable_one;
    next_periph_irq_enable_two = periph_irq_enable_two;
    next_pwm_irq_enable = pwm_irq_enable;
    next_periph_irq_request_one = periph_irq_request_one;
    next_periph_irq_request_two = periph_irq_request_two;
    next_evt_mask = evt_mask;
    if (wr && hit) begin
      case (apb_i.paddr)
        OFS_CORE_CTRL: next_core_irq_control = wdat & MASK_CORE_CTRL;
        OFS_ENABLE_ONE:
          next_periph_irq_enable_one = wdat & MASK_ONE;
        OFS_ENABLE_TWO:
          next_periph_irq_enable_two = wdat & MASK_TWO;
        OFS_PWM_ENABLE: next_pwm_irq_enable = wdat & MASK_PWM;
        OFS_REQUEST_ONE:
          next_periph_irq_request_one = wdat & MASK_ONE;
        OFS_REQUEST_TWO:
          next_periph_irq_request_two = wdat & MASK_TWO;
        OFS_EVT_MASK: next_evt_mask = wdat[EVT_W-1:0];
        default: next_evt_mask = evt_mask;
      endcase
    end
    // A condition in the same cycle as a software clear still sets the flag.
    next_periph_irq_request_one =
      next_periph_irq_request_one | (set_one & MASK_ONE);
    next_periph_irq_request_two =
      next_periph_irq_request_two | (set_two & MASK_TWO);
    // Wave bits only follow the channels; bus writes never reach them.
    next_pwm_irq_request = set_pwm & MASK_PWM;
  end

  // Combined request and its gating.
  always_comb begin
    any_pending = |(periph_irq_request_one & periph_irq_enable_one)
      | |(periph_irq_request_two & periph_irq_enable_two)
      | |(pwm_irq_request & pwm_irq_enable);
    next_periph_req = any_pending;
    next_core_irq = any_pending
      && core_irq_control[BIT_PERIPH_EN]
      && core_irq_control[BIT_GLOBAL_EN];
  end

  // Event status, write-one-to-clear with set winning over clear.
  always_comb begin
    next_evt_status = evt_status;
    if (wr && apb_i.paddr == OFS_EVT_STATUS) begin
      next_evt_status = evt_status & ~wdat[EVT_W-1:0];
    end
    if (next_core_irq && !core_irq) begin
      next_evt_status[EVT_RISE] = 1'b1;
    end
    if (!next_core_irq && core_irq) begin
      next_evt_status[EVT_FALL] = 1'b1;
    end
    if (access && !hit) begin
      next_evt_status[EVT_ERR] = 1'b1;
    end
    next_evt_irq = |(next_evt_status & next_evt_mask);
  end

  // Bus answer registered for the access cycle that follows setup.
  always_comb begin
    next_rsp = '0;
    if (apb_i.psel && !apb_i.penable) begin
      next_rsp.pready = 1'b1;
      next_rsp.pslverr = !hit;
      if (!apb_i.pwrite) begin
        next_rsp.prdata = {{(DATA_W-REG_W){1'b0}}, rdat};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_irq_control <= REG_RESET;
      periph_irq_enable_one <= REG_RESET;
      periph_irq_enable_two <= REG_RESET;
      pwm_irq_enable <= REG_RESET;
      periph_irq_request_one <= REG_RESET;
      periph_irq_request_two <= REG_RESET;
      pwm_irq_request <= REG_RESET;
      evt_status <= '0;
      evt_mask <= '0;
      rsp <= '0;
      periph_req <= 1'b0;
      core_irq <= 1'b0;
      evt_irq <= 1'b0;
    end else begin
      core_irq_control <= next_core_irq_control;
      periph_irq_enable_one <= next_periph_irq_enable_one;
      periph_irq_enable_two <= next_periph_irq_enable_two;
      pwm_irq_enable <= next_pwm_irq_enable;
      periph_irq_request_one <= next_periph_irq_request_one;
      periph_irq_request_two <= next_periph_irq_request_two;
      pwm_irq_request <= next_pwm_irq_request;
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      rsp <= next_rsp;
      periph_req <= next_periph_req;
      core_irq <= next_core_irq;
      evt_irq <= next_evt_irq;
    end
  end

  assign apb_o = rsp;
  assign periph_req_o = periph_req;
  assign core_irq_o = core_irq;
  assign evt_irq_o = evt_irq;

  // Checks.
  sequence s_write_one(logic [ADDR_W-1:0] a);
    apb_i.psel && apb_i.penable && apb_i.pwrite && apb_i.paddr == a;
  endsequence

  property p_pwm_enable_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_write_one(OFS_PWM_ENABLE)
      |=> pwm_irq_enable == ($past(wdat) & MASK_PWM);
  endproperty
  a_pwm_enable_write: assert property (p_pwm_enable_write)
    else $error("wave enable register did not take the write");

  property p_unimpl_zero;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ((periph_irq_enable_one & ~MASK_ONE) == '0)
      && ((periph_irq_request_two & ~MASK_TWO) == '0)
      && ((pwm_irq_enable & ~MASK_PWM) == '0)
      && ((core_irq_control & ~MASK_CORE_CTRL) == '0)
      && ((periph_irq_request_one & ~MASK_ONE) == '0)
      && ((pwm_irq_request & ~MASK_PWM) == '0)
      && (rsp.prdata[DATA_W-1:REG_W] == '0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit is not zero");

  property p_req_one_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_write_one(OFS_REQUEST_ONE) ##0 (set_one == '0)
      |=> periph_irq_request_one == ($past(wdat) & MASK_ONE);
  endproperty
  a_req_one_write: assert property (p_req_one_write)
    else $error("request register one did not take the write");

  property p_req_two_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_write_one(OFS_REQUEST_TWO) ##0 !cond_i.comparator
      |=> periph_irq_request_two == ($past(wdat) & MASK_TWO);
  endproperty
  a_req_two_write: assert property (p_req_two_write)
    else $error("request register two did not take the write");

  property p_cond_sets;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      cond_i.serial_rx |=> periph_irq_request_one[BIT_SER_RX];
  endproperty
  a_cond_sets: assert property (p_cond_sets)
    else $error("receive condition did not set its flag");

  property p_wave_mirror;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ##1 pwm_irq_request == ($past(set_pwm) & MASK_PWM);
  endproperty
  a_wave_mirror: assert property (p_wave_mirror)
    else $error("wave request bits do not follow the channels");

  property p_periph_gate;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !core_irq_control[BIT_PERIPH_EN] |=> !core_irq;
  endproperty
  a_periph_gate: assert property (p_periph_gate)
    else $error("request passed with peripheral enable clear");

  // The core request lags the control bits by one cycle, as does the
  // combined request behind the flags, so both are compared together.
  property p_global_gate;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      core_irq_control[BIT_PERIPH_EN] && core_irq_control[BIT_GLOBAL_EN]
      |=> core_irq == periph_req;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("enabled request did not reach the core");

  property p_global_block;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !core_irq_control[BIT_GLOBAL_EN] |=> !core_irq;
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("request passed with global enable clear");

  property p_ctrl_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_write_one(OFS_CORE_CTRL)
      |=> core_irq_control == ($past(wdat) & MASK_CORE_CTRL);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control register did not take the write");

  property p_enable_one_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_write_one(OFS_ENABLE_ONE)
      |=> periph_irq_enable_one == ($past(wdat) & MASK_ONE);
  endproperty
  a_enable_one_write: assert property (p_enable_one_write)
    else $error("enable register one did not take the write");

  property p_enable_two_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_write_one(OFS_ENABLE_TWO)
      |=> periph_irq_enable_two == ($past(wdat) & MASK_TWO);
  endproperty
  a_enable_two_write: assert property (p_enable_two_write)
    else $error("enable register two did not take the write");

  property p_comparator_sets;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      cond_i.comparator |=> periph_irq_request_two[BIT_COMPARATOR];
  endproperty
  a_comparator_sets: assert property (p_comparator_sets)
    else $error("comparator condition did not set its flag");

  sequence s_any_enabled;
    (periph_irq_request_one & periph_irq_enable_one) != '0
    || (periph_irq_request_two & periph_irq_enable_two) != '0
    || (pwm_irq_request & pwm_irq_enable) != '0;
  endsequence

  property p_req_raise;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_any_enabled |=> periph_req;
  endproperty
  a_req_raise: assert property (p_req_raise)
    else $error("enabled flag did not raise the request");

  property p_req_quiet;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (periph_irq_request_one & periph_irq_enable_one) == '0
      && (periph_irq_request_two & periph_irq_enable_two) == '0
      && (pwm_irq_request & pwm_irq_enable) == '0 |=> !periph_req;
  endproperty
  a_req_quiet: assert property (p_req_quiet)
    else $error("request raised with no enabled flag");

  // Reset is checked from its second sampled edge, once the
  // asynchronous clear has surely acted on every register.
  sequence s_held_reset;
    !rst_b_i ##1 !rst_b_i;
  endsequence

  property p_reset_zero;
    @(posedge ref_clk_i)
      s_held_reset |-> core_irq_control == REG_RESET
      && periph_irq_enable_one == REG_RESET
      && periph_irq_enable_two == REG_RESET
      && pwm_irq_enable == REG_RESET
      && periph_irq_request_one == REG_RESET
      && periph_irq_request_two == REG_RESET
      && pwm_irq_request == REG_RESET
      && evt_status == '0 && evt_mask == '0
      && !core_irq && !periph_req && !evt_irq && !rsp.pready;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("register or output not cleared by reset");

endmodule : periph_irq_flags

// ### tb/periph_model.sv
// Behavioural model of the peripherals that feed the interrupt flags.
`timescale 1ns/1ps

module periph_model
  import periph_irq_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Commands from the bench.
  input wire periph_irq_pkg::periph_cond_t fire_i,
  input wire periph_irq_pkg::wave_flags_t set_i,
  input wire periph_irq_pkg::wave_flags_t clr_i,
  // Towards the flag block.
  output periph_irq_pkg::periph_cond_t cond_o,
  output periph_irq_pkg::wave_flags_t wave_o
);
  import periph_irq_pkg::*;

  // Channel flags live here and clear only by a clear command or a reset.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cond_o <= '0;
      wave_o <= '0;
    end else begin
      cond_o <= fire_i;
      wave_o <= (wave_o | set_i) & ~clr_i;
    end
  end
endmodule : periph_model

// ### tb/tb.sv
// Self-checking bench of the peripheral interrupt flag block.
`timescale 1ns/1ps

module tb;
  import periph_irq_pkg::*;

  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  periph_cond_t fire = '0;
  periph_cond_t cond;
  wave_flags_t wset = '0;
  wave_flags_t wclr = '0;
  wave_flags_t wave;
  logic preq;
  logic cirq;
  logic eirq;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] q;
  logic e;

  always #5 ref_clk_i = ~ref_clk_i;

  periph_model model_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .fire_i(fire), .set_i(wset), .clr_i(wclr), .cond_o(cond), .wave_o(wave));

  periph_irq_flags dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .apb_i(req), .apb_o(rsp), .cond_i(cond), .wave_flags_i(wave),
    .periph_req_o(preq), .core_irq_o(cirq), .evt_irq_o(eirq));

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(0, 1, "bus hang");
      close_out();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, '0);
    chk(q, x, "read");
  endtask : rd

  task automatic cyc;
    repeat (3) @(posedge ref_clk_i);
  endtask : cyc

  task automatic t_reset;
    logic [7:0] a [9] = '{OFS_CORE_CTRL, OFS_ENABLE_ONE, OFS_ENABLE_TWO,
      OFS_PWM_ENABLE, OFS_REQUEST_ONE, OFS_REQUEST_TWO, OFS_PWM_REQUEST,
      OFS_EVT_STATUS, OFS_EVT_MASK};
    foreach (a[i]) rd(a[i], 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_enables;
    logic [7:0] a [3] = '{OFS_ENABLE_ONE, OFS_ENABLE_TWO, OFS_PWM_ENABLE};
    logic [7:0] m [3] = '{MASK_ONE, MASK_TWO, MASK_PWM};
    foreach (a[i]) begin
      bus(1'b1, a[i], 32'hFFFF_FFFF);
      rd(a[i], {24'h0, m[i]});
      bus(1'b1, a[i], 32'h0);
      rd(a[i], 32'h0);
    end
    $display("enable test done");
  endtask : t_enables

  task automatic t_flags;
    @(posedge ref_clk_i);
    fire <= '1;
    @(posedge ref_clk_i);
    fire <= '0;
    cyc();
    chk(preq, 0, "req with enables off");
    rd(OFS_REQUEST_ONE, 32'hF3);
    rd(OFS_REQUEST_TWO, 32'h20);
    bus(1'b1, OFS_REQUEST_ONE, 32'h0);
    bus(1'b1, OFS_REQUEST_TWO, 32'h0);
    rd(OFS_REQUEST_ONE, 32'h0);
    rd(OFS_REQUEST_TWO, 32'h0);
    bus(1'b1, OFS_REQUEST_ONE, 32'hFF);
    rd(OFS_REQUEST_ONE, 32'hF3);
    bus(1'b1, OFS_REQUEST_ONE, 32'h0);
    $display("flag test done");
  endtask : t_flags

  task automatic t_gate;
    logic [7:0] c [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    // Flag is clear before its enable is set.
    bus(1'b1, OFS_ENABLE_TWO, 32'h20);
    @(posedge ref_clk_i);
    fire <= '{comparator: 1'b1, default: 1'b0};
    @(posedge ref_clk_i);
    fire <= '0;
    foreach (c[i]) begin
      bus(1'b1, OFS_CORE_CTRL, {24'h0, c[i]});
      cyc();
      chk(preq, 1, "periph req");
      chk(cirq, c[i] == 8'hC0, "core irq gating");
      rd(OFS_CORE_CTRL, {24'h0, c[i]});
    end
    bus(1'b1, OFS_REQUEST_TWO, 32'h0);
    cyc();
    chk(preq, 0, "req after clear");
    chk(cirq, 0, "irq after clear");
    $display("gating test done");
  endtask : t_gate

  task automatic t_wave;
    bus(1'b1, OFS_PWM_ENABLE, 32'h70);
    @(posedge ref_clk_i);
    wset <= '1;
    @(posedge ref_clk_i);
    wset <= '0;
    cyc();
    rd(OFS_PWM_REQUEST, 32'h70);
    chk(cirq, 1, "wave irq");
    bus(1'b1, OFS_PWM_REQUEST, 32'h0);
    chk(e, 0, "wave write error");
    rd(OFS_PWM_REQUEST, 32'h70);
    @(posedge ref_clk_i);
    wclr <= '{chan2: 1'b1, default: 1'b0};
    @(posedge ref_clk_i);
    wclr <= '0;
    cyc();
    rd(OFS_PWM_REQUEST, 32'h50);
    chk(cirq, 1, "wave irq after one clear");
    @(posedge ref_clk_i);
    wclr <= '1;
    @(posedge ref_clk_i);
    wclr <= '0;
    cyc();
    rd(OFS_PWM_REQUEST, 32'h0);
    cyc();
    chk(preq, 0, "wave req cleared");
    $display("wave test done");
  endtask : t_wave

  task automatic t_evt;
    bus(1'b1, OFS_EVT_MASK, 32'h7);
    rd(OFS_EVT_MASK, 32'h7);
    bus(1'b1, OFS_EVT_STATUS, 32'h7);
    cyc();
    chk(eirq, 0, "evt irq cleared");
    rd(8'h40, 32'h0);
    chk(e, 1, "unmapped error");
    rd(OFS_EVT_STATUS, 32'h4);
    chk(eirq, 1, "evt irq raised");
    bus(1'b1, OFS_EVT_MASK, 32'h0);
    cyc();
    chk(eirq, 0, "evt irq masked");
    bus(1'b1, OFS_EVT_STATUS, 32'h4);
    rd(OFS_EVT_STATUS, 32'h0);
    $display("event test done");
  endtask : t_evt

  // A reset in mid-run must clear everything as the first one did.
  task automatic t_rerst;
    bus(1'b1, OFS_ENABLE_ONE, 32'hFF);
    bus(1'b1, OFS_REQUEST_ONE, 32'h01);
    cyc();
    chk(cirq, 1, "irq before reset");
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    chk(cirq, 0, "irq after reset");
    chk(preq, 0, "req after reset");
    t_reset();
    $display("second reset test done");
  endtask : t_rerst

  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_enables();
    t_flags();
    t_gate();
    t_wave();
    t_evt();
    t_rerst();
    close_out();
  end
endmodule : tb
